// ==== core/mpc_debug_host.v ====
// Multi-processor debug controller: drives a core's debug halt and run
// four-phase handshakes and its reset start-state level.
// Assumes one clock; core outputs arrive asynchronously and are synchronised here.
//
// Behaviour
// - Controller drops halt request once it sees halt acknowledge high.
// - Controller never issues two halt requests back to back.
// - Unused interface ties the halt request low.
// - Run request drops after acknowledge; acknowledge drops after request drops.
// - Controller never issues two run requests back to back.
// - Unused interface ties the run request low.
// - Start-state level is made synchronous to the core clock outside the core.
// - Unused interface ties the start-state level high.
// - Controller raises run request only while core reports debugger-halted state.
// - When started halted, no run request before core is in Debug Mode.
// - Core outputs are synchronised in the controller; requests and start level leave the controller registered.
// - Power manager wakes a power-halted core with its own run request.
`timescale 1ns/100ps
`default_nettype none
`include "mpc_host_defines.vh"

module mpc_debug_host (
    input  wire clock,
    input  wire rst,
    input  wire hostEnable,
    input  wire startRunCfg,
    input  wire haltCmd,
    input  wire runCmd,
    output wire haltCmdReady,
    output wire runCmdReady,
    output reg  haltDone,
    output reg  runDone,
    output reg  cmdRefused,
    output wire busy,
    output wire coreInDebug,
    output wire coreBrkptHit,
    output reg  debugHaltReq,
    output reg  debugRunReq,
    output reg  resetRunReq,
    input  wire debugHaltAck,
    input  wire debugRunAck,
    input  wire debugModeStatus,
    input  wire debugBrkptStatus
);

    reg [`ST_WIDTH-1:0]   state_reg;
    reg [`ST_WIDTH-1:0]   state_next;
    reg [`LAST_WIDTH-1:0] last_reg;
    reg [`LAST_WIDTH-1:0] last_next;
    reg                   haltDone_next;
    reg                   runDone_next;
    reg                   refused_next;
    reg                   haltReq_next;
    reg                   runReq_next;

    // Two-stage synchronisers; stage 0 feeds only stage 1.
    reg [3:0]             sync0_reg;
    reg [3:0]             sync1_reg;

    wire haltAckSync;
    wire runAckSync;
    wire modeSync;
    wire brkptSync;
    wire idle;
    wire haltAccept;
    wire runAccept;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sync0_reg <= 4'h0;
            sync1_reg <= 4'h0;
        end else begin
            sync0_reg <= {debugBrkptStatus, debugModeStatus, debugRunAck, debugHaltAck};
            sync1_reg <= sync0_reg;
        end
    end

    assign haltAckSync  = sync1_reg[0];
    assign runAckSync   = sync1_reg[1];
    assign modeSync     = sync1_reg[2];
    assign brkptSync    = sync1_reg[3];
    assign coreInDebug  = modeSync;
    assign coreBrkptHit = brkptSync;

    assign idle = (state_reg == `ST_IDLE);
    assign busy = ~idle;

    // A halt may not follow a halt; a run may not follow a run and needs Debug Mode.
    assign haltCmdReady = idle & hostEnable & (last_reg != `LAST_HALT);
    assign runCmdReady  = idle & hostEnable & (last_reg != `LAST_RUN) & modeSync;
    assign haltAccept   = haltCmd & haltCmdReady;
    assign runAccept    = runCmd & runCmdReady & ~haltCmd;

    always @* begin
        state_next    = state_reg;
        last_next     = last_reg;
        haltDone_next = 1'b0;
        runDone_next  = 1'b0;
        refused_next  = 1'b0;
        haltReq_next  = 1'b0;
        runReq_next   = 1'b0;
        case (state_reg)
            `ST_IDLE: begin
                if (haltAccept) begin
                    state_next   = `ST_HALT_REQ;
                    haltReq_next = 1'b1;
                end else if (runAccept) begin
                    state_next  = `ST_RUN_REQ;
                    runReq_next = 1'b1;
                end else if (haltCmd | runCmd) begin
                    refused_next = 1'b1;
                end
            end
            `ST_HALT_REQ: begin
                if (haltAckSync) begin
                    state_next = `ST_HALT_DROP;
                end else begin
                    haltReq_next = hostEnable;
                end
                if (~hostEnable) begin
                    state_next = `ST_HALT_DROP;
                end
            end
            `ST_HALT_DROP: begin
                if (~haltAckSync) begin
                    state_next    = `ST_IDLE;
                    last_next     = `LAST_HALT;
                    haltDone_next = 1'b1;
                end
            end
            `ST_RUN_REQ: begin
                if (runAckSync) begin
                    state_next = `ST_RUN_DROP;
                end else begin
                    runReq_next = hostEnable;
                end
                if (~hostEnable) begin
                    state_next = `ST_RUN_DROP;
                end
            end
            `ST_RUN_DROP: begin
                if (~runAckSync) begin
                    state_next   = `ST_IDLE;
                    last_next    = `LAST_RUN;
                    runDone_next = 1'b1;
                end
            end
            default: begin
                state_next = `ST_IDLE;
            end
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg    <= `ST_IDLE;
            last_reg     <= `LAST_NONE;
            haltDone     <= 1'b0;
            runDone      <= 1'b0;
            cmdRefused   <= 1'b0;
            debugHaltReq <= 1'b0;
            debugRunReq  <= 1'b0;
            resetRunReq  <= `START_RUN;
        end else begin
            state_reg    <= state_next;
            last_reg     <= last_next;
            haltDone     <= haltDone_next;
            runDone      <= runDone_next;
            cmdRefused   <= refused_next;
            debugHaltReq <= haltReq_next;
            debugRunReq  <= runReq_next;
            // Registered on this clock so the core sees a synchronous level.
            resetRunReq  <= hostEnable ? startRunCfg : `START_RUN;
        end
    end

endmodule

`default_nettype wire

// ==== shared/mpc_host_defines.vh ====
// Constants for the multi-processor debug controller that drives a core's
// debug halt/run handshake pins.
// Assumes inclusion by bare name from the design file that uses it.
`ifndef MPC_HOST_DEFINES_VH
`define MPC_HOST_DEFINES_VH

// Handshake sequencer states.
`define ST_IDLE       3'h0
`define ST_HALT_REQ   3'h1
`define ST_HALT_DROP  3'h2
`define ST_RUN_REQ    3'h3
`define ST_RUN_DROP   3'h4
`define ST_WIDTH      3

// Kind of the last completed request, used to forbid repeats.
`define LAST_NONE     2'h0
`define LAST_HALT     2'h1
`define LAST_RUN      2'h2
`define LAST_WIDTH    2

// Start-state level for the core: 1 runs, 0 starts debugger-halted.
`define START_RUN     1'h1
`define START_HALTED  1'h0

// Depth of the synchroniser on each input coming back from the core.
`define SYNC_DEPTH    2

`endif

// ==== tb/mpc_core_model.sv ====
// Behavioural core that answers the debug halt and run handshakes.
// Assumes it shares the clock and reset of the controller under test.
`timescale 1ns/100ps
`default_nettype none
module mpc_core_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic lag,
    input  wire logic haltReq,
    input  wire logic runReq,
    input  wire logic startRun,
    output var  logic haltAck,
    output var  logic runAck,
    output var  logic inDebug,
    output wire logic brkHit
);
    logic [1:0] seen;
    assign brkHit = 1'b0;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            {seen, haltAck, runAck, inDebug} <= 5'h00;
        end else begin
            seen <= (seen == 2'h2) ? seen : seen + 2'h1;
            if (seen == 2'h1)
                inDebug <= ~startRun;
            if (haltReq & ~lag)
                inDebug <= 1'b1;
            // A high lag stands for the core's own debugger or a pending power halt.
            if (runReq & ~lag)
                inDebug <= 1'b0;
            haltAck <= haltReq & (inDebug | haltAck);
            runAck <= runReq & (~inDebug | runAck);
        end
    end
endmodule
`default_nettype wire

// ==== tb/mpc_debug_host_properties.sv ====
// Port assertions for the debug controller.
// Assumes one clock and an active-high reset.
`timescale 1ns/100ps
`default_nettype none
module mpc_debug_host_properties (
    input wire logic clock, rst, hostEnable, startRunCfg, haltCmdReady, runCmdReady,
    input wire logic haltDone, runDone, coreInDebug, debugHaltReq, debugRunReq,
    input wire logic resetRunReq, debugHaltAck, debugRunAck
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence hUp; $rose(debugHaltAck); endsequence
    sequence rUp; $rose(debugRunAck); endsequence
    halt_drop_a: assert property (hUp |-> ##[1:5] !debugHaltReq) else $error("halt held");
    run_drop_a: assert property (rUp |-> ##[1:5] !debugRunReq) else $error("run held");
    halt_repeat_a: assert property (haltDone |=> !haltCmdReady) else $error("halt twice");
    run_repeat_a: assert property (runDone |=> !runCmdReady) else $error("run twice");
    unused_req_a: assert property (!hostEnable |=> !debugHaltReq && !debugRunReq)
        else $error("request while unused");
    unused_start_a: assert property (!hostEnable |=> resetRunReq) else $error("start low");
    start_copy_a: assert property (hostEnable |=> resetRunReq == $past(startRunCfg))
        else $error("start level wrong");
    run_gate_a: assert property ($rose(debugRunReq) |-> $past(coreInDebug))
        else $error("run outside debug");
endmodule
bind mpc_debug_host mpc_debug_host_properties i_props (.clock(clock), .rst(rst),
    .hostEnable(hostEnable), .startRunCfg(startRunCfg), .haltCmdReady(haltCmdReady),
    .runCmdReady(runCmdReady), .haltDone(haltDone), .runDone(runDone),
    .coreInDebug(coreInDebug), .debugHaltReq(debugHaltReq), .debugRunReq(debugRunReq),
    .resetRunReq(resetRunReq), .debugHaltAck(debugHaltAck), .debugRunAck(debugRunAck));
`default_nettype wire

// ==== tb/mpc_debug_host_tb.sv ====
// Self-checking bench: controller against a behavioural core.
// Assumes both share one clock; the core answers with random lag.
`timescale 1ns/100ps
`default_nettype none
module mpc_debug_host_tb;
    logic clock, rst, hostEnable, startRunCfg, haltCmd, runCmd, lag, r;
    wire hReq, rReq, sReq, hAck, rAck, dMode, bStat, hRdy, rRdy, hDone, rDone, refd, busy;
    wire inDbg, brk;
    integer seed = 32'hAD7B, failures = 0, total_checks = 0, i, n;
    mpc_debug_host i_dut (.clock(clock), .rst(rst), .hostEnable(hostEnable),
        .startRunCfg(startRunCfg), .haltCmd(haltCmd), .runCmd(runCmd), .haltCmdReady(hRdy),
        .runCmdReady(rRdy), .haltDone(hDone), .runDone(rDone), .cmdRefused(refd), .busy(busy),
        .coreInDebug(inDbg), .coreBrkptHit(brk), .debugHaltReq(hReq), .debugRunReq(rReq),
        .resetRunReq(sReq), .debugHaltAck(hAck), .debugRunAck(rAck), .debugModeStatus(dMode),
        .debugBrkptStatus(bStat));
    mpc_core_model i_core (.clock(clock), .rst(rst), .lag(lag), .haltReq(hReq), .runReq(rReq),
        .startRun(sReq), .haltAck(hAck), .runAck(rAck), .inDebug(dMode), .brkHit(bStat));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(negedge clock) lag = $random(seed) > 0;
    function logic expStart(input logic en, input logic cfg);
        return en ? cfg : 1'b1;
    endfunction
    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t mismatch", $time);
        end
    endtask
    task cmd(input logic h, input logic ok);
        chk(h ? hRdy : rRdy, ok);
        haltCmd = h;
        runCmd = ~h;
        @(negedge clock);
        {haltCmd, runCmd} = 2'h0;
        r = refd;
        @(negedge clock);
        chk(r | refd, ~ok);
        chk(busy, ok);
        for (n = 0; n < 90 && ok && !(h ? hDone : rDone); n++) @(negedge clock);
        if (ok) begin
            chk(h ? hDone : rDone, 1'b1);
            chk(inDbg, h);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run needs about 400 cycles; allow some 20000.
    initial begin
        #500000;
        failures++;
        results;
    end
    initial begin
        {rst, hostEnable, startRunCfg, haltCmd, runCmd, lag, r} = 7'h60;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        chk(sReq, expStart(hostEnable, startRunCfg));
        chk(inDbg, 1'b1);
        cmd(1'b0, 1'b1);
        cmd(1'b0, 1'b0);
        for (i = 0; i < 12; i++) begin
            repeat ($unsigned($random(seed)) % 5) @(negedge clock);
            startRunCfg = $random(seed);
            @(negedge clock);
            chk(sReq, expStart(hostEnable, startRunCfg));
            cmd(1'b1, 1'b1);
            cmd(1'b1, 1'b0);
            cmd(1'b0, 1'b1);
        end
        $display("test handshakes done");
        hostEnable = 1'b0;
        repeat (3) @(negedge clock);
        chk(sReq, expStart(hostEnable, startRunCfg));
        chk(hReq | rReq, 1'b0);
        chk(brk, 1'b0);
        $display("test unused done");
        results;
    end
endmodule
`default_nettype wire
